// ==== hw/msu_top.sv ====
// multimode serial port with apb register access
`timescale 1ns/100ps
`default_nettype none
`include "msu_consts.svh"
// Behaviour
// - bit rate is clock over 16 times divisor plus one; fixed mode over 16
// - data writes load the transmitter; data reads return a separate receive buffer
// - new byte may arrive before old is read; unread old byte is overwritten
// - any write to the data register starts a transmission in every mode
// - shift mode receives only with receive pending clear and receive enable set
// - asynchronous modes start receiving on a low start bit when enabled
// - reset clears the control register to zero
// - receive pending sets after eighth bit, or at mid stop bit
// - transmit pending sets after eighth bit, or at start of stop bit
// - receive or transmit pending flag plus its enable bit requests an interrupt; overrun has no enable or interrupt
// - shift mode drives shift clock on transmit pin, data on receive pin, lsb first
// - control bits 7:6 select one of four modes
// - mode 1 frames: low start, eight data lsb first, high stop
// - mode 1 receive stores the stop bit into the ninth bit field
// - nine-bit modes send control bit 3, store received ninth bit in bit 2
// - mode 3 matches mode 2 framing but uses the divisor rate
// - with filter enabled, nine-bit frames with ninth bit zero raise nothing
module msu_top (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // serial pins; receive pin is two-way in shift mode
  input wire logic rxd_in,
  output logic rxd_out,
  output logic rxd_oe,
  output logic txd,
  // interrupt requests
  output logic rx_irq,
  output logic tx_irq
);
  msu_pkg::msu_top_regs_type st_reg, st_next;
  msu_pkg::msu_mode_type mode;
  logic tick;
  logic tx_txd;
  logic tx_done;
  logic setup;
  logic acc;
  logic hit;
  logic [1:0] sel;
  logic wr;
  logic tx_go;
  logic shift_mode;
  logic nine;
  logic rx_done;
  logic rx_accept;
  logic rx_load;
  logic [7:0] rx_byte;
  logic rx_ninth;
  logic rx_set;
  logic tx_set;
  logic ovr_set;
  logic [3:0] rx_last;

  // ----------------------------------------------------------------
  // mode and bus phase decode
  // ----------------------------------------------------------------

  assign mode = msu_pkg::msu_mode_type'(st_reg.ctl[`MSU_BIT_MODE_HI:`MSU_BIT_MODE_LO]);
  assign shift_mode = (mode == msu_pkg::MSU_MODE_SHIFT);
  assign nine = st_reg.ctl[`MSU_BIT_MODE_HI];
  assign rx_last = nine ? `MSU_LAST_BIT9 : `MSU_LAST_BIT8;
  assign setup = psel && !penable;
  assign acc = psel && penable && st_reg.pready;
  assign wr = acc && pwrite && hit;
  assign tx_go = wr && sel == 2'd2;

  // address decode; anything else answers with an error
  always_comb begin
    hit = 1'b1;
    sel = 2'd0;
    if (paddr == {2'b00, `MSU_IDX_CONTROL, 2'b00}) begin
      sel = 2'd0;
    end else if (paddr == {2'b00, `MSU_IDX_PENDING, 2'b00}) begin
      sel = 2'd1;
    end else if (paddr == {2'b00, `MSU_IDX_DATA, 2'b00}) begin
      sel = 2'd2;
    end else if (paddr == {2'b00, `MSU_IDX_BAUD, 2'b00}) begin
      sel = 2'd3;
    end else begin
      hit = 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // rate and transmit engines
  // ----------------------------------------------------------------

  msu_baud msu_baud_inst (
    .pclk(pclk),
    .presetn(presetn),
    .divisor(st_reg.baud),
    .fixed_rate(mode == msu_pkg::MSU_MODE_UART9_FIXED),
    .tick(tick)
  );

  // shift mode never uses the framed transmitter
  msu_tx msu_tx_inst (
    .pclk(pclk),
    .presetn(presetn),
    .tick(tick),
    .nine_bit(nine),
    .start(tx_go && !shift_mode),
    .data(pwdata[7:0]),
    .bit9(st_reg.ctl[`MSU_BIT_TX9]),
    .txd(tx_txd),
    .done(tx_done)
  );

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------

  always_comb begin
    st_next = st_reg;
    rx_done = 1'b0;
    rx_accept = 1'b0;
    rx_load = 1'b0;
    rx_byte = 8'h00;
    rx_ninth = 1'b0;
    rx_set = 1'b0;
    tx_set = tx_done;
    ovr_set = 1'b0;

    // zero-wait answer: registered in setup, valid in access
    st_next.pready = setup;
    if (setup) begin
      st_next.pslverr = !hit;
      if (!hit || pwrite) begin
        st_next.prdata = 32'h0000_0000;
      end else if (sel == 2'd0) begin
        st_next.prdata = {24'h00_0000, st_reg.ctl};
      end else if (sel == 2'd1) begin
        st_next.prdata = {29'h0000_0000, st_reg.pnd};
      end else if (sel == 2'd2) begin
        st_next.prdata = {24'h00_0000, st_reg.rxbuf};
      end else begin
        st_next.prdata = {24'h00_0000, st_reg.baud};
      end
    end else if (!psel) begin
      st_next.pslverr = 1'b0;
    end

    // register writes take effect at the completing edge
    if (wr && sel == 2'd0) begin
      st_next.ctl = pwdata[7:0];
    end
    if (wr && sel == 2'd3) begin
      st_next.baud = pwdata[7:0];
    end
    if (acc && !pwrite && hit && sel == 2'd2) begin
      st_next.rx_unread = 1'b0;
    end

    // asynchronous receiver, paced by the sixteen-times tick
    if (shift_mode) begin
      st_next.rst = msu_pkg::MSU_RX_IDLE;
    end else if (tick) begin
      case (st_reg.rst)
        msu_pkg::MSU_RX_IDLE: begin
          if (st_reg.ctl[`MSU_BIT_RXEN] && !rxd_in) begin
            st_next.rst = msu_pkg::MSU_RX_START;
            st_next.rph = 4'h0;
          end
        end
        msu_pkg::MSU_RX_START: begin
          st_next.rph = st_reg.rph + 4'h1;
          // a glitch shorter than half a bit is dropped here
          if (st_reg.rph == `MSU_MID_TICK) begin
            if (!rxd_in) begin
              st_next.rst = msu_pkg::MSU_RX_DATA;
              st_next.rph = 4'h0;
              st_next.rbit = 4'h0;
            end else begin
              st_next.rst = msu_pkg::MSU_RX_IDLE;
            end
          end
        end
        msu_pkg::MSU_RX_DATA: begin
          st_next.rph = st_reg.rph + 4'h1;
          if (st_reg.rph == `MSU_LAST_TICK) begin
            st_next.rsh = {rxd_in, st_reg.rsh[8:1]};
            st_next.rbit = st_reg.rbit + 4'h1;
            if (st_reg.rbit == rx_last) begin
              st_next.rst = msu_pkg::MSU_RX_STOP;
            end
          end
        end
        default: begin
          st_next.rph = st_reg.rph + 4'h1;
          if (st_reg.rph == `MSU_LAST_TICK) begin
            st_next.rst = msu_pkg::MSU_RX_IDLE;
            rx_done = 1'b1;
          end
        end
      endcase
    end

    // frame end: nine-bit modes keep bit 9, mode 1 keeps the stop bit
    if (rx_done) begin
      if (nine) begin
        rx_byte = st_reg.rsh[7:0];
        rx_ninth = st_reg.rsh[8];
      end else begin
        rx_byte = st_reg.rsh[8:1];
        rx_ninth = rxd_in;
      end
      // filter drops address-less frames, or bad stops in mode 1
      rx_accept = !(st_reg.ctl[`MSU_BIT_MPEN] && !rx_ninth);
      if (rx_accept) begin
        st_next.ctl[`MSU_BIT_RX9] = rx_ninth;
        rx_load = 1'b1;
      end
    end

    // shift mode engine: device makes the clock, lsb first
    if (!shift_mode) begin
      st_next.m0_act = 1'b0;
    end else if (tx_go) begin
      st_next.m0_act = 1'b1;
      st_next.m0_rx = 1'b0;
      st_next.m0_sh = pwdata[7:0];
      st_next.m0_ph = 4'h0;
      st_next.m0_bit = 4'h0;
    end else if (!st_reg.m0_act) begin
      if (st_reg.ctl[`MSU_BIT_RXEN] && !st_reg.pnd[`MSU_PND_RX]) begin
        st_next.m0_act = 1'b1;
        st_next.m0_rx = 1'b1;
        st_next.m0_ph = 4'h0;
        st_next.m0_bit = 4'h0;
      end
    end else if (tick) begin
      st_next.m0_ph = st_reg.m0_ph + 4'h1;
      // receive samples on the rising shift clock edge
      if (st_reg.m0_rx && st_reg.m0_ph == `MSU_MID_TICK) begin
        st_next.m0_sh = {rxd_in, st_reg.m0_sh[7:1]};
      end
      if (st_reg.m0_ph == `MSU_LAST_TICK) begin
        st_next.m0_bit = st_reg.m0_bit + 4'h1;
        if (!st_reg.m0_rx) begin
          st_next.m0_sh = {1'b0, st_reg.m0_sh[7:1]};
        end
        if (st_reg.m0_bit == `MSU_LAST_BIT8) begin
          st_next.m0_act = 1'b0;
          if (st_reg.m0_rx) begin
            rx_byte = st_reg.m0_sh;
            rx_load = 1'b1;
          end else begin
            tx_set = 1'b1;
          end
        end
      end
    end

    // receive buffer; an unread byte is lost to the new one
    if (rx_load) begin
      st_next.rxbuf = rx_byte;
      rx_set = 1'b1;
      ovr_set = st_reg.rx_unread;
      st_next.rx_unread = 1'b1;
    end

    // pending flags: software writes, hardware set wins
    if (wr && sel == 2'd1) begin
      st_next.pnd = pwdata[2:0];
    end
    if (rx_set) begin
      st_next.pnd[`MSU_PND_RX] = 1'b1;
    end
    if (tx_set) begin
      st_next.pnd[`MSU_PND_TX] = 1'b1;
    end
    if (ovr_set) begin
      st_next.pnd[`MSU_PND_OVR] = 1'b1;
    end

    // pins: shift clock low for the first half bit, idle high
    if (shift_mode) begin
      st_next.txd = !st_next.m0_act || st_next.m0_ph[3];
    end else begin
      st_next.txd = tx_txd;
    end
    st_next.rxd_out = st_next.m0_sh[0];
    st_next.rxd_oe = shift_mode && st_next.m0_act && !st_next.m0_rx;

    // interrupt requests follow pending and enable
    st_next.rx_irq = st_next.pnd[`MSU_PND_RX] && st_next.ctl[`MSU_BIT_RXIE];
    st_next.tx_irq = st_next.pnd[`MSU_PND_TX] && st_next.ctl[`MSU_BIT_TXIE];
  end

  // ----------------------------------------------------------------
  // state register
  // ----------------------------------------------------------------

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_reg <= '0;
      st_reg.ctl <= `MSU_CTL_RESET;
      st_reg.pnd <= `MSU_PND_RESET;
      st_reg.baud <= `MSU_BAUD_RESET;
      st_reg.txd <= 1'b1;
    end else begin
      st_reg <= st_next;
    end
  end

  assign prdata = st_reg.prdata;
  assign pready = st_reg.pready;
  assign pslverr = st_reg.pslverr;
  assign rxd_out = st_reg.rxd_out;
  assign rxd_oe = st_reg.rxd_oe;
  assign txd = st_reg.txd;
  assign rx_irq = st_reg.rx_irq;
  assign tx_irq = st_reg.tx_irq;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_ctl_reset_zero: assert property ($rose(presetn) |-> st_reg.ctl == 8'h00)
    else $error("control not zero after reset");
  a_data_read_buf: assert property (
    setup && !pwrite && hit && sel == 2'd2 |=> prdata == {24'h00_0000, $past(st_reg.rxbuf)})
    else $error("data read did not return receive buffer");
  a_overrun_flag: assert property (rx_load && st_reg.rx_unread |=> st_reg.pnd[2])
    else $error("overrun not flagged");
  a_tx_start_async: assert property (
    tx_go && !shift_mode && st_reg.ctl[7:6] == st_next.ctl[7:6] |-> ##[1:3] !txd)
    else $error("write did not start frame");
  a_m0_rx_hold: assert property (
    shift_mode && !st_reg.m0_act && st_reg.pnd[1] && !tx_go |=> !st_reg.m0_act)
    else $error("shift receive began with pending set");
  a_rx_pend_set: assert property (rx_load |=> st_reg.pnd[1])
    else $error("receive pending not set");
  a_rx_irq_follow: assert property (
    rx_set && st_next.ctl[`MSU_BIT_RXIE] |=> rx_irq)
    else $error("receive interrupt missing");
  a_m0_oe_mode: assert property (rxd_oe |-> $past(shift_mode) && $past(st_next.m0_act))
    else $error("data pin driven outside shift transmit");
  a_stop_to_ninth: assert property (
    rx_done && rx_accept && !nine |=> st_reg.ctl[2] == $past(rxd_in))
    else $error("stop bit not stored");
  a_filter_drop: assert property (
    rx_done && nine && st_reg.ctl[5] && !st_reg.rsh[8] |-> !rx_set)
    else $error("filtered frame set pending");
  a_start_recheck: assert property (
    tick && st_reg.rst == msu_pkg::MSU_RX_START && st_reg.rph == 4'h7 && rxd_in
    |=> st_reg.rst == msu_pkg::MSU_RX_IDLE)
    else $error("false start bit accepted");

  c_async_rx: cover property (rx_done && rx_accept);
  c_m0_rx: cover property (shift_mode && rx_load);
  c_overrun: cover property (ovr_set);
  c_tx_done: cover property (tx_done);
endmodule
`default_nettype wire

// ==== common/msu_consts.svh ====
// register indices, field positions, reset values and bit timing of the serial port
`ifndef MSU_CONSTS_SVH
`define MSU_CONSTS_SVH
// register indices; byte address is four times the index
`define MSU_IDX_CONTROL 8'hf5
`define MSU_IDX_PENDING 8'hf6
`define MSU_IDX_DATA 8'hf8
`define MSU_IDX_BAUD 8'hf9
// reset values
`define MSU_CTL_RESET 8'h00
`define MSU_PND_RESET 3'h0
`define MSU_BAUD_RESET 8'h00
// serial_control fields
`define MSU_BIT_MODE_HI 7
`define MSU_BIT_MODE_LO 6
`define MSU_BIT_MPEN 5
`define MSU_BIT_RXEN 4
`define MSU_BIT_TX9 3
`define MSU_BIT_RX9 2
`define MSU_BIT_RXIE 1
`define MSU_BIT_TXIE 0
// serial_pending fields
`define MSU_PND_TX 0
`define MSU_PND_RX 1
`define MSU_PND_OVR 2
// sixteen ticks per bit: sample at mid tick, bit ends at last tick
`define MSU_MID_TICK 4'h7
`define MSU_LAST_TICK 4'hf
`define MSU_LAST_BIT8 4'h7
`define MSU_LAST_BIT9 4'h8
// receive interrupt vector
`define MSU_RX_VECTOR 8'hfa
`endif

// ==== common/msu_pkg.sv ====
// types shared by the serial port modules
package msu_pkg;
  // operating mode from serial_control bits 7:6
  typedef enum logic [1:0] {
    MSU_MODE_SHIFT = 2'b00,
    MSU_MODE_UART8 = 2'b01,
    MSU_MODE_UART9_FIXED = 2'b10,
    MSU_MODE_UART9_VAR = 2'b11
  } msu_mode_type;
  // transmit and receive frame states
  typedef enum logic [1:0] {
    MSU_TX_IDLE = 2'b00,
    MSU_TX_START = 2'b01,
    MSU_TX_DATA = 2'b10,
    MSU_TX_STOP = 2'b11
  } msu_txst_type;
  typedef enum logic [1:0] {
    MSU_RX_IDLE = 2'b00,
    MSU_RX_START = 2'b01,
    MSU_RX_DATA = 2'b10,
    MSU_RX_STOP = 2'b11
  } msu_rxst_type;
  // module state records
  typedef struct packed {
    logic [7:0] cnt;
    logic tick;
  } msu_baud_regs_type;
  typedef struct packed {
    msu_txst_type st;
    logic [3:0] phase;
    logic [3:0] nbit;
    logic [8:0] shift;
    logic txd;
    logic done;
  } msu_tx_regs_type;
  typedef struct packed {
    logic [7:0] ctl;
    logic [2:0] pnd;
    logic [7:0] baud;
    logic [7:0] rxbuf;
    logic rx_unread;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    msu_rxst_type rst;
    logic [3:0] rph;
    logic [3:0] rbit;
    logic [8:0] rsh;
    logic m0_act;
    logic m0_rx;
    logic [3:0] m0_ph;
    logic [3:0] m0_bit;
    logic [7:0] m0_sh;
    logic txd;
    logic rxd_out;
    logic rxd_oe;
    logic rx_irq;
    logic tx_irq;
  } msu_top_regs_type;
endpackage

// ==== hw/msu_baud.sv ====
// sixteen-times bit-rate tick generator
`timescale 1ns/100ps
`default_nettype none
module msu_baud (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // rate selection
  input wire logic [7:0] divisor,
  input wire logic fixed_rate,
  // one pulse per sixteenth of a bit
  output logic tick
);
  msu_pkg::msu_baud_regs_type st_reg, st_next;

  // reload at the limit; fixed rate ticks every clock
  always_comb begin
    st_next = st_reg;
    st_next.tick = 1'b0;
    if (fixed_rate || st_reg.cnt >= divisor) begin
      st_next.cnt = 8'h00;
      st_next.tick = 1'b1;
    end else begin
      st_next.cnt = st_reg.cnt + 8'h01;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign tick = st_reg.tick;

  a_tick_gap: assert property (@(posedge pclk) disable iff (!presetn)
    tick && !fixed_rate && divisor == 8'h01 |=> !tick ##1 tick)
    else $error("baud tick spacing wrong");
endmodule
`default_nettype wire

// ==== hw/msu_tx.sv ====
// asynchronous frame transmitter: start, 8 or 9 data bits, stop
`timescale 1ns/100ps
`default_nettype none
`include "msu_consts.svh"
module msu_tx (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // timing and format
  input wire logic tick,
  input wire logic nine_bit,
  // load request
  input wire logic start,
  input wire logic [7:0] data,
  input wire logic bit9,
  // line and completion
  output logic txd,
  output logic done
);
  msu_pkg::msu_tx_regs_type st_reg, st_next;
  logic [3:0] last_bit;

  assign last_bit = nine_bit ? `MSU_LAST_BIT9 : `MSU_LAST_BIT8;

  // a load restarts the frame at once, even mid-frame
  always_comb begin
    st_next = st_reg;
    st_next.done = 1'b0;
    if (start) begin
      st_next.st = msu_pkg::MSU_TX_START;
      st_next.phase = 4'h0;
      st_next.nbit = 4'h0;
      st_next.shift = {bit9, data};
      st_next.txd = 1'b0;
    end else if (tick && st_reg.st != msu_pkg::MSU_TX_IDLE) begin
      st_next.phase = st_reg.phase + 4'h1;
      if (st_reg.phase == `MSU_LAST_TICK) begin
        case (st_reg.st)
          msu_pkg::MSU_TX_START: begin
            st_next.st = msu_pkg::MSU_TX_DATA;
            st_next.txd = st_reg.shift[0];
            st_next.shift = {1'b1, st_reg.shift[8:1]};
          end
          msu_pkg::MSU_TX_DATA: begin
            st_next.nbit = st_reg.nbit + 4'h1;
            if (st_reg.nbit == last_bit) begin
              st_next.st = msu_pkg::MSU_TX_STOP;
              st_next.txd = 1'b1;
              st_next.done = 1'b1;
            end else begin
              st_next.txd = st_reg.shift[0];
              st_next.shift = {1'b1, st_reg.shift[8:1]};
            end
          end
          default: begin
            st_next.st = msu_pkg::MSU_TX_IDLE;
          end
        endcase
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_reg <= '0;
      st_reg.txd <= 1'b1;
    end else begin
      st_reg <= st_next;
    end
  end

  assign txd = st_reg.txd;
  assign done = st_reg.done;

  a_tx_start_low: assert property (@(posedge pclk) disable iff (!presetn)
    start |=> !txd)
    else $error("start bit not driven low");
  a_tx_done_stop: assert property (@(posedge pclk) disable iff (!presetn)
    done |-> txd && st_reg.st == msu_pkg::MSU_TX_STOP)
    else $error("transmit done not at stop bit");
endmodule
`default_nettype wire

// ==== bench/msu_far_end.sv ====
// far-end serial peer: sends frames to the port and catches frames from it
`timescale 1ns/100ps
`default_nettype none
module msu_far_end (
  // clock
  input wire logic pclk,
  // serial lines
  input wire logic txd,
  output logic line_out
);
  int bt = 16; // clocks per bit, set by the bench
  // line rests high between frames, like a pulled-up pin
  initial line_out = 1'b1;
  // low start, n bits lsb first, high stop left on the line
  task automatic send(input logic [8:0] d, input int n);
    for (int i = 0; i < n + 2; i++) begin
      line_out <= (i == 0) ? 1'b0 : (i > n) ? 1'b1 : d[i-1];
      repeat (bt) @(posedge pclk);
    end
  endtask
  // wait for a start bit, then sample each bit at its centre
  task automatic grab(input int n, output logic [9:0] f);
    int k;
    logic lost;
    f = '1;
    for (k = 0; k < 9000 && txd !== 1'b0; k++) @(posedge pclk);
    lost = (txd !== 1'b0);
    repeat (bt / 2) @(posedge pclk);
    for (k = 0; k <= n; k++) begin
      repeat (bt) @(posedge pclk);
      f[k] = txd;
    end
    // a start bit that never came must fail the frame compare
    if (lost) begin
      f = 'x;
    end
  endtask
  // short low pulse on an idle line, then a quiet frame time
  task automatic glitch(input int w);
    line_out <= 1'b0;
    repeat (w) @(posedge pclk);
    line_out <= 1'b1;
    repeat (bt * 10) @(posedge pclk);
  endtask
endmodule
`default_nettype wire

// ==== bench/msu_top_bench.sv ====
// self-checking bench for the multimode serial port
`timescale 1ns/100ps
`default_nettype none
`include "msu_consts.svh"
module msu_top_bench;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, perr;
  logic rxd_out, rxd_oe, txd, rx_irq, tx_irq, far_line, rxd_line;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rv;
  logic [9:0] f;
  int bad_count = 0;
  int samples_checked = 0;
  // the data pin shows the device while it drives, else the far end
  assign rxd_line = rxd_oe ? rxd_out : far_line;
  msu_top msu_top_inst (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .rxd_in(rxd_line), .rxd_out(rxd_out), .rxd_oe(rxd_oe), .txd(txd),
    .rx_irq(rx_irq), .tx_irq(tx_irq));
  msu_far_end msu_far_end_inst (.pclk(pclk), .txd(txd), .line_out(far_line));
  // 100 MHz clock
  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end
  // ----
  // checking and bus tasks
  // ----
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      bad_count++;
      $display("FAIL %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic end_sim;
    if (bad_count == 0 && samples_checked > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  // one transfer; request held until pready is seen high at an edge
  task automatic apb(input logic w, input logic [7:0] idx, input logic [7:0] wd);
    int k;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= {2'b00, idx, 2'b00};
    pwdata <= {24'h000000, wd};
    @(posedge pclk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge pclk);
      k++;
    end while (pready !== 1'b1 && k < 50);
    if (k >= 50) begin
      bad_count++;
      end_sim();
    end
    rv = prdata;
    perr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] idx, input logic [7:0] v);
    apb(1'b1, idx, v);
  endtask
  task automatic rd(input logic [7:0] idx);
    apb(1'b0, idx, 8'h00);
  endtask
  // ----
  // scenarios
  // ----
  // one byte out through the transmitter, caught at the far end
  task automatic tx_frame(input logic [7:0] ctl, input logic [7:0] div, input int bt,
      input int n, input logic [7:0] d);
    logic [9:0] e;
    e = (n == 8) ? {2'b11, d} : {1'b1, ctl[3], d};
    wr(`MSU_IDX_BAUD, div);
    wr(`MSU_IDX_CONTROL, ctl);
    wr(`MSU_IDX_PENDING, 8'h00);
    msu_far_end_inst.bt = bt;
    fork
      msu_far_end_inst.grab(n, f);
      begin
        wr(`MSU_IDX_DATA, d);
        rd(`MSU_IDX_PENDING);
        chk("tx pending early", rv, 32'h0);
      end
    join
    chk("tx frame", {22'h0, f}, {22'h0, e});
    rd(`MSU_IDX_PENDING);
    chk("tx pending", rv, 32'h1);
    chk("tx irq", {31'h0, tx_irq}, 32'h1);
  endtask
  task automatic s_tx;
    tx_frame(8'h41, 8'h00, 16, 8, 8'ha5);
    tx_frame(8'h89, 8'h02, 16, 9, 8'h3c);
    tx_frame(8'hc1, 8'h02, 48, 9, 8'hc3);
  endtask
  // far end sends; flags and control are read back
  task automatic rx_check(input logic [8:0] d, input int n, input logic [7:0] pexp,
      input logic [7:0] cexp);
    msu_far_end_inst.send(d, n);
    rd(`MSU_IDX_PENDING);
    chk("rx pending", rv, {24'h0, pexp});
    rd(`MSU_IDX_CONTROL);
    chk("rx control", rv, {24'h0, cexp});
  endtask
  task automatic s_rx;
    wr(`MSU_IDX_BAUD, 8'h00);
    wr(`MSU_IDX_CONTROL, 8'h40);
    wr(`MSU_IDX_PENDING, 8'h00);
    msu_far_end_inst.bt = 16;
    rx_check(9'h077, 8, 8'h00, 8'h40);
    wr(`MSU_IDX_CONTROL, 8'h52);
    rx_check(9'h05a, 8, 8'h02, 8'h56);
    chk("rx irq", {31'h0, rx_irq}, 32'h1);
    rd(`MSU_IDX_DATA);
    chk("rx data", rv, 32'h5a);
    wr(`MSU_IDX_PENDING, 8'h00);
    msu_far_end_inst.send(9'h011, 8);
    rx_check(9'h022, 8, 8'h06, 8'h56);
    rd(`MSU_IDX_DATA);
    chk("overrun data", rv, 32'h22);
    wr(`MSU_IDX_PENDING, 8'h00);
    msu_far_end_inst.glitch(4);
    rd(`MSU_IDX_PENDING);
    chk("glitch ignored", rv, 32'h0);
    // mode 1 with the filter on: a zero stop bit drops the frame
    wr(`MSU_IDX_CONTROL, 8'h72);
    rx_check(9'h055, 9, 8'h00, 8'h72);
    wr(`MSU_IDX_CONTROL, 8'hb2);
    wr(`MSU_IDX_PENDING, 8'h00);
    rx_check(9'h033, 9, 8'h00, 8'hb2);
    rx_check(9'h144, 9, 8'h02, 8'hb6);
    rd(`MSU_IDX_DATA);
    chk("nine bit data", rv, 32'h44);
  endtask
  // shift mode: device clocks data out, then in from an idle-high pin
  task automatic s_shift;
    logic [7:0] got;
    logic prev;
    int k, m, lows;
    wr(`MSU_IDX_CONTROL, 8'h00);
    wr(`MSU_IDX_PENDING, 8'h00);
    wr(`MSU_IDX_DATA, 8'h96);
    prev = txd;
    m = 0;
    for (k = 0; k < 600 && m < 8; k++) begin
      @(posedge pclk);
      if (txd === 1'b1 && prev === 1'b0) begin
        got = {rxd_line, got[7:1]};
        m++;
      end
      prev = txd;
    end
    chk("shift out", {24'h0, got}, 32'h96);
    repeat (16) @(posedge pclk);
    rd(`MSU_IDX_PENDING);
    chk("shift tx pending", rv, 32'h1);
    wr(`MSU_IDX_PENDING, 8'h00);
    wr(`MSU_IDX_CONTROL, 8'h10);
    for (k = 0; k < 100 && rv[1] !== 1'b1; k++) rd(`MSU_IDX_PENDING);
    chk("shift rx pending", rv, 32'h2);
    rd(`MSU_IDX_DATA);
    chk("shift in", rv, 32'hff);
    lows = 0;
    for (k = 0; k < 64; k++) begin
      @(posedge pclk);
      lows += (txd !== 1'b1);
    end
    chk("no clock while pending", lows, 32'h0);
  endtask
  task automatic s_reset;
    rd(`MSU_IDX_CONTROL);
    chk("control reset", rv, 32'h0);
    rd(8'h00);
    chk("unmapped error", {31'h0, perr}, 32'h1);
  endtask
  // ----
  // main sequence
  // ----
  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = '0;
    pwdata = '0;
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    s_reset();
    s_tx();
    s_rx();
    s_shift();
    end_sim();
  end
endmodule
`default_nettype wire
